// [hdl/guard_timer_pkg.sv]
// Purpose: shared constants for the counter array guard timer
// Assumes: one 50 MHz clock, counting advances on counter array ticks
// Notes: timeout is 2**(BASE + select) ticks of the counter array source

package guard_timer_pkg;

  // system clock rate, used only to document timing figures
  localparam int unsigned CLK_HZ = 50_000_000;

  // guard timer count width and timeout select width
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SEL_W = 3;

  // smallest timeout is 2**BASE_SHIFT ticks; select adds to the exponent
  localparam logic [4:0] BASE_SHIFT = 5'h09;

  // after any reset: longest interval, timer enabled
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h7;
  localparam logic             ENABLE_RESET = 1'h1;

  // cycles the device stays in its reset state after the last cause drops
  localparam int unsigned HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_CYCLES = 8'h10;

  // idle level of the active-low reset pin, also the synchroniser's reset value
  localparam logic PIN_IDLE = 1'h1;

endpackage : guard_timer_pkg

// [hdl/guard_timer_if.sv]
// Purpose: carries control and status between the guard timer shell and its counter
// Assumes: both ends sit on the same clock
// Notes: ctrl is the shell, core is the counter

`timescale 1ns/1ps

interface guard_timer_if;
  import guard_timer_pkg::*;

  logic                 ce;        // clock enable, freezes the counter
  logic                 tick;      // counter array clock source tick
  logic                 enable;    // timer counting allowed
  logic [SEL_W-1:0]     sel;       // timeout select
  logic                 restart;   // software restart pulse
  logic                 init;      // device held in reset
  logic                 overflow;  // one-cycle overflow pulse

  modport ctrl (output ce, tick, enable, sel, restart, init, input overflow);
  modport core (input ce, tick, enable, sel, restart, init, output overflow);
endinterface : guard_timer_if

// [hdl/guard_timer_core.sv]
// Purpose: guard timer count and overflow detection
// Assumes: tick comes from the counter array clock selection, same clock domain
// Notes: overflow is a registered one-cycle pulse

`timescale 1ns/1ps

module guard_timer_core
  import guard_timer_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // link to the shell
  guard_timer_if.core gt
);

  logic [CNT_W-1:0] count_reg;    // ticks since last restart
  logic [CNT_W-1:0] count_next;
  logic             ovf_reg;      // overflow pulse
  logic             ovf_next;
  logic [CNT_W:0]   span;         // timeout length in ticks
  logic [CNT_W-1:0] term;         // last count before overflow

  // terminal count from the programmed select
  always_comb begin
    span = {{CNT_W{1'b0}}, 1'b1} << (BASE_SHIFT + {2'h0, gt.sel});
    term = CNT_W'(span - {{CNT_W{1'b0}}, 1'b1});
  end

  // next count: cleared by restart, reset or disable; advanced on ticks only
  always_comb begin
    count_next = count_reg;
    ovf_next   = 1'b0;
    if (gt.init || gt.restart || !gt.enable) begin
      // restart only zeroes the count, select and enable live in the shell
      count_next = '0;
    end else if (gt.tick) begin
      if (count_reg == term) begin
        count_next = '0;
        ovf_next   = 1'b1;
      end else begin
        count_next = count_reg + CNT_W'(1);
      end
    end
  end

  // register the count; ce low freezes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      ovf_reg   <= 1'b0;
    end else if (gt.ce) begin
      count_reg <= count_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign gt.overflow = ovf_reg;

endmodule : guard_timer_core

// [hdl/counter_array_watchdog.sv]
// Purpose: guard timer of the counter array, with the device reset sequencer around it
// Assumes: software controls arrive as same-clock strobes; reset pin is asynchronous
// Notes: no register bus; control bits are plain ports

`timescale 1ns/1ps

module counter_array_watchdog
  import guard_timer_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // counter array clock source
  input  wire logic             array_tick,
  // software controls, same clock, one-cycle strobes
  input  wire logic             sw_restart,
  input  wire logic             sw_disable,
  input  wire logic             sw_enable,
  input  wire logic             sw_sel_wr,
  input  wire logic [SEL_W-1:0] sw_sel,
  input  wire logic             sw_cause_clr,
  // external reset pin, active low, open drain
  input  wire logic             reset_pin_low_in,
  output logic                  reset_pin_low_out,
  output logic                  reset_pin_low_oe,
  // device-side effects of the reset state
  output logic                  sys_reset,
  output logic                  core_halt,
  output logic                  ram_write_block,
  // status
  output logic                  wd_running,
  output logic [SEL_W-1:0]      wd_sel,
  output logic                  wd_reset_seen
);

  typedef enum logic {RUN_ST, HOLD_ST} seq_state_type;

  guard_timer_if gt ();

  // ---------------------------------------------------------------
  // reset pin synchroniser: three stages, s1 feeds only s2
  // ---------------------------------------------------------------
  logic pin_s1_reg;      // first stage, metastability catch
  logic pin_s2_reg;      // second stage
  logic pin_s3_reg;      // third stage
  logic pin_lvl_reg;     // accepted pin level
  logic pin_s1_next;
  logic pin_s2_next;
  logic pin_s3_next;
  logic pin_lvl_next;

  // accept a change only once stages two and three agree
  always_comb begin
    pin_s1_next  = reset_pin_low_in;
    pin_s2_next  = pin_s1_reg;
    pin_s3_next  = pin_s2_reg;
    pin_lvl_next = pin_lvl_reg;
    if (pin_s2_reg == pin_s3_reg) begin
      pin_lvl_next = pin_s3_reg;
    end
  end

  // idle level is high so the pin does not look asserted out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg  <= PIN_IDLE;
      pin_s2_reg  <= PIN_IDLE;
      pin_s3_reg  <= PIN_IDLE;
      pin_lvl_reg <= PIN_IDLE;
    end else if (ce) begin
      pin_s1_reg  <= pin_s1_next;
      pin_s2_reg  <= pin_s2_next;
      pin_s3_reg  <= pin_s3_next;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  seq_state_type     state_reg;    // running or held in reset
  seq_state_type     state_next;
  logic [HOLD_W-1:0] hold_reg;     // cycles left in reset state
  logic [HOLD_W-1:0] hold_next;
  logic              cause_reg;    // last reset came from the timer
  logic              cause_next;
  logic              pin_req;      // reset pin asserted

  assign pin_req = !pin_lvl_reg;

  // overflow or pin enters reset; leave after the hold count runs out
  always_comb begin
    state_next = state_reg;
    hold_next  = hold_reg;
    cause_next = cause_reg;
    if (state_reg == RUN_ST && sw_cause_clr) begin
      cause_next = 1'b0;
    end
    if (pin_req) begin
      cause_next = 1'b0;
    end
    // set wins over both clears in the same cycle
    if (gt.overflow) begin
      cause_next = 1'b1;
    end
    unique case (state_reg)
      RUN_ST: begin
        if (gt.overflow || pin_req) begin
          state_next = HOLD_ST;
          hold_next  = HOLD_CYCLES;
        end
      end
      HOLD_ST: begin
        if (pin_req) begin
          // pin still low: stretch the reset
          hold_next = HOLD_CYCLES;
        end else if (hold_reg == HOLD_W'(1)) begin
          state_next = RUN_ST;
          hold_next  = '0;
        end else begin
          hold_next = hold_reg - HOLD_W'(1);
        end
      end
    endcase
  end

  // power-up counts as a reset, so start in the hold state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HOLD_ST;
      hold_reg  <= HOLD_CYCLES;
      cause_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      hold_reg  <= hold_next;
      cause_reg <= cause_next;
    end
  end

  // ---------------------------------------------------------------
  // timer configuration held for software
  // ---------------------------------------------------------------
  logic             en_reg;    // timer enabled
  logic             en_next;
  logic [SEL_W-1:0] sel_reg;   // timeout select
  logic [SEL_W-1:0] sel_next;

  // software writes are ignored while the core is halted
  always_comb begin
    en_next  = en_reg;
    sel_next = sel_reg;
    if (state_reg == HOLD_ST) begin
      en_next  = ENABLE_RESET;
      sel_next = SEL_RESET;
    end else begin
      if (sw_disable) begin
        en_next = 1'b0;
      end else if (sw_enable) begin
        en_next = 1'b1;
      end
      if (sw_sel_wr) begin
        sel_next = sw_sel;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg  <= ENABLE_RESET;
      sel_reg <= SEL_RESET;
    end else if (ce) begin
      en_reg  <= en_next;
      sel_reg <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // timer counter
  // ---------------------------------------------------------------
  assign gt.ce      = ce;
  assign gt.tick    = array_tick;
  assign gt.enable  = en_reg;
  assign gt.sel     = sel_reg;
  // restart is honoured only while the core runs; software must keep it coming
  assign gt.restart = sw_restart && (state_reg == RUN_ST);
  assign gt.init    = (state_reg == HOLD_ST);

  guard_timer_core u_core (
    .clk   (clk),
    .rst_n (rst_n),
    .gt    (gt)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic out_rst_reg;    // device reset state
  logic out_rst_next;

  // outputs follow the next state so they line up with the state register
  always_comb begin
    out_rst_next = (state_next == HOLD_ST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_rst_reg <= 1'b1;
    end else if (ce) begin
      out_rst_reg <= out_rst_next;
    end
  end

  assign sys_reset       = out_rst_reg;
  assign core_halt       = out_rst_reg;
  // writes blocked in reset so stored data survives it
  assign ram_write_block = out_rst_reg;
  assign wd_running      = en_reg;
  assign wd_sel          = sel_reg;
  assign wd_reset_seen   = cause_reg;

  // pin driver registers stay released; a timer reset leaves the pin alone
  logic pin_oe_reg;
  logic pin_out_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_reg  <= 1'b0;
      pin_out_reg <= 1'b0;
    end else if (ce) begin
      pin_oe_reg  <= 1'b0;
      pin_out_reg <= 1'b0;
    end
  end

  assign reset_pin_low_oe  = pin_oe_reg;
  assign reset_pin_low_out = pin_out_reg;

endmodule : counter_array_watchdog

// [verif/counter_array_watchdog_props.sv]
// Purpose: port-level checks of the counter array guard timer
// Assumes: one clock, asynchronous active-low reset
// Notes: the hold span is only judged while ce is high at entry

`timescale 1ns/1ps

module counter_array_watchdog_props
  import guard_timer_pkg::*;
(
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  // stimulus side
  input wire logic             array_tick,
  input wire logic             sw_restart,
  input wire logic             sw_disable,
  input wire logic             sw_enable,
  input wire logic             sw_sel_wr,
  input wire logic [SEL_W-1:0] sw_sel,
  input wire logic             sw_cause_clr,
  input wire logic             reset_pin_low_in,
  // design outputs
  input wire logic             reset_pin_low_out,
  input wire logic             reset_pin_low_oe,
  input wire logic             sys_reset,
  input wire logic             core_halt,
  input wire logic             ram_write_block,
  input wire logic             wd_running,
  input wire logic [SEL_W-1:0] wd_sel,
  input wire logic             wd_reset_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // the pin is open drain; this reset source must leave it alone
  a_pin_not_driven: assert property (!reset_pin_low_oe) else $error("reset pin driven");
  a_halt_tracks_reset: assert property (core_halt == sys_reset) else $error("core halt off reset");
  a_ram_guard_tracks: assert property (ram_write_block == sys_reset) else $error("ram guard off reset");
  a_overflow_enters_reset: assert property ($rose(wd_reset_seen) |-> $rose(sys_reset))
    else $error("overflow without reset state");
  // a little slack on the exit edge, the sequencer hold is a design choice
  a_reset_hold_span: assert property ($rose(sys_reset) && wd_reset_seen && ce
    |-> sys_reset [*8] ##1 sys_reset [*7] ##[1:3] !sys_reset) else $error("hold span wrong");
  a_exit_defaults: assert property ($fell(sys_reset) |-> wd_running && wd_sel == SEL_RESET)
    else $error("exit without defaults");
  a_sel_loads: assert property (sw_sel_wr && ce && !sys_reset |=> sys_reset || wd_sel == $past(sw_sel))
    else $error("select not loaded");
  a_disable_stops: assert property (sw_disable && ce && !sys_reset |=> sys_reset || !wd_running)
    else $error("disable ignored");
  a_enable_starts: assert property (sw_enable && !sw_disable && ce && !sys_reset |=> wd_running)
    else $error("enable ignored");
  // an overflow already in flight at the disable edge may still land
  a_off_no_overflow: assert property (!wd_running && !$past(wd_running) |=> !$rose(wd_reset_seen))
    else $error("overflow while off");

  // main scenarios reached
  c_overflow: cover property ($rose(wd_reset_seen));
  c_exit: cover property ($fell(sys_reset));
  c_reenable: cover property (!wd_running ##1 sw_enable);
endmodule : counter_array_watchdog_props

bind counter_array_watchdog counter_array_watchdog_props props (.clk, .rst_n, .ce, .array_tick, .sw_restart,
  .sw_disable, .sw_enable, .sw_sel_wr, .sw_sel, .sw_cause_clr, .reset_pin_low_in, .reset_pin_low_out,
  .reset_pin_low_oe, .sys_reset, .core_halt, .ram_write_block, .wd_running, .wd_sel, .wd_reset_seen);

// [verif/tb_counter_array_watchdog.sv]
// Purpose: self-checking bench for the counter array guard timer
// Assumes: inputs change at the falling edge, outputs are read before each rising edge updates
// Notes: status word is sys, halt, ram, oe, out, running, select, seen

`timescale 1ns/1ps

module tb_counter_array_watchdog;
  import guard_timer_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, array_tick = 0, sw_restart = 0, sw_disable = 0;
  logic sw_enable = 0, sw_sel_wr = 0, sw_cause_clr = 0, reset_pin_low_in = 1;
  logic [SEL_W-1:0] sw_sel = '0;
  logic reset_pin_low_out, reset_pin_low_oe, sys_reset, core_halt, ram_write_block, wd_running, wd_reset_seen;
  logic [SEL_W-1:0] wd_sel;
  logic [19:0]      notes[$];  // mask over expected status, oldest first
  int               failures = 0, cmp_count = 0, n;
  wire logic [9:0]  status = {sys_reset, core_halt, ram_write_block, reset_pin_low_oe, reset_pin_low_out,
                              wd_running, wd_sel, wd_reset_seen};

  counter_array_watchdog uut (.clk, .rst_n, .ce, .array_tick, .sw_restart, .sw_disable, .sw_enable,
    .sw_sel_wr, .sw_sel, .sw_cause_clr, .reset_pin_low_in, .reset_pin_low_out, .reset_pin_low_oe,
    .sys_reset, .core_halt, .ram_write_block, .wd_running, .wd_sel, .wd_reset_seen);

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // masked-off bits are left open where the design has no fixed value
  task automatic note(logic [9:0] exp, logic [9:0] m = 10'h3ff);
    notes.push_back({m, exp & m});
    @(negedge clk);
  endtask : note

  // one-cycle strobe
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse

  // bounded wait for the reset state to reach a level
  task automatic wait_sys(logic v);
    n = 0;
    while (sys_reset !== v && n < 80) begin
      @(negedge clk);
      n++;
    end
    check("sys_reset", {9'h0, sys_reset}, {9'h0, v});
  endtask : wait_sys

  // reads before the edge's own updates, so the compare never races the design
  always @(posedge clk) begin
    if (notes.size() != 0) begin
      check("status", status & notes[0][19:10], notes[0][9:0]);
      void'(notes.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h5c0beb8f));
    repeat (4) @(negedge clk);
    note(10'h39e);
    rst_n = 1;
    wait_sys(0);
    note(10'h01e);
    for (int s = 7; s >= 0; s--) begin
      sw_sel = 3'(s);
      pulse(sw_sel_wr);
      note({6'h01, 3'(s), 1'b0}, 10'h01e);
    end
    // random tick density; restart after 500 ticks, three times, each short of the 512 tick timeout
    pulse(sw_restart);
    repeat (3) begin
      n = 0;
      while (n < 500) begin
        array_tick = 1'($urandom % 2);
        @(negedge clk);
        n += int'(array_tick);
      end
      array_tick = 0;
      pulse(sw_restart);
    end
    note(10'h010);
    array_tick = 1;
    repeat (511) @(negedge clk);
    array_tick = 0;
    note(10'h010);
    array_tick = 1;
    @(negedge clk);
    array_tick = 0;
    @(negedge clk);
    note(10'h381, 10'h3e1);
    wait_sys(0);
    note(10'h01f);
    pulse(sw_cause_clr);
    note(10'h01e);
    sw_sel = '0;
    pulse(sw_sel_wr);
    pulse(sw_disable);
    array_tick = 1;
    repeat (600) @(negedge clk);
    array_tick = 0;
    note(10'h000);
    pulse(sw_enable);
    note(10'h010);
    // ce low freezes the count: 600 ticks past a 512 tick timeout must not overflow
    ce = 0;
    array_tick = 1;
    repeat (600) @(negedge clk);
    ce = 1;
    array_tick = 0;
    note(10'h010);
    reset_pin_low_in = 0;
    wait_sys(1);
    note(10'h380, 10'h3e1);
    reset_pin_low_in = 1;
    wait_sys(0);
    note(10'h01e);
    complete_run();
  end

  // a hang ends the run as a mismatch
  initial begin
    #200us;
    check("run time", 10'h1, 10'h0);
    complete_run();
  end
endmodule : tb_counter_array_watchdog
